// ===== common/port_cfg.svh
// Offsets, field positions, codes and timing counts for the debug port
`ifndef PORT_CFG_SVH
`define PORT_CFG_SVH
`define CTRL_OFF 12'h000
`define STAT_OFF 12'h004
`define CMP_OFF 12'h008
`define CTRL_RUN_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_SINGLE_BIT 2
`define CTRL_RESET 3'h0
`define IDLE_NIB 4'h3
`define HEADER_TAG 2'h2
`define NOT_READY 4'h0
`define READY 4'h1
`define CMD_ERR 4'h3
`define BUS_ERR 4'h5
`define CMD_READ 4'h1
`define CMD_WRITE 4'h2
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2
`define SIZE_BAD 2'h3
`define CMP_RESET 32'h0000_0000
`define ADDR_LAST 3'h7
`define PIN_HIGH_NIB 4'hF
`define HDR_DELAY_MIN 4'h3
`define HDR_DELAY_MAX 4'h4
`endif

// ===== common/port_pkg.sv
// State types of the debug trace and monitor port
package port_pkg;
	typedef enum logic [1:0] {TR_IDLE, TR_HEADER, TR_ADDR} trace_state_type;
	typedef enum logic [2:0] {
		MON_CMD, MON_SIZE, MON_ADDR, MON_DATA, MON_ACCESS, MON_STATUS, MON_READ
	} mon_state_type;
endpackage

// ===== rtl/bit_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module bit_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	if (WIDTH < 1) begin : g_check
		$error("bit_sync needs at least one bit");
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ===== rtl/access_check.sv
// Combinational check of a monitor access against the bus error cases
`timescale 1ns/1ps
`include "port_cfg.svh"
module access_check #(
	parameter logic [31:0] IO8_BASE = 32'hFFFF_8000,
	parameter logic [31:0] IO8_LIMIT = 32'hFFFF_83FF,
	parameter logic [31:0] EXT_BASE = 32'h0040_0000
) (
	input wire logic [31:0] addr,
	input wire logic [1:0] size,
	input wire logic single_chip,
	output logic fault
);
	if (IO8_LIMIT < IO8_BASE) begin : g_check
		$error("access_check region limit below its base");
	end

	wire word_odd = (size == `SIZE_WORD) && addr[0];
	wire long_misaligned = (size == `SIZE_LONG) && (addr[1:0] != 2'h0);
	wire in_io8 = (addr >= IO8_BASE) && (addr <= IO8_LIMIT);
	wire long_io8 = (size == `SIZE_LONG) && in_io8;
	// Nothing answers outside the chip when no external bus exists
	wire ext_single = single_chip && (addr >= EXT_BASE);

	assign fault = word_odd || long_misaligned || long_io8 || ext_single;
endmodule

// ===== rtl/debug_trace_monitor_port.sv
// Debug port: branch trace output and RAM monitor access over a nibble link
// Overview of operation
// - Mode pin low at reset release: trace
// - Trace link clock runs at half rate
// - Idle trace nibbles show 0011
// - Header 10 plus size code, then address
// - Size from matching upper address bits
// - Address nibbles go out lowest first
// - Compared address resets to zero
// - After last nibble: sync released, 0011
// - New branch restarts header and output
// - Only completed addresses update comparison
// - Header starts 1.5 or 2 link clocks
// - Mode pin high at reset release: monitor
// - Monitor captures nibbles while sync asserted
// - Access runs; status 0000 then 0001
// - Read data follows sync release after ready
// - Undefined command sets status bit 1
// - Bus error sets bit 2; bit 3 zero
// - Misaligned, io8 long, external single-chip fault
// - Pin, soft bit or stop bit reset port
// - Standby keeps monitor status not ready
// - Standby halts trace, release resumes it
// - In reset pins high or inputs by mode; stop bit floats all pins
// - Software releases port after pin reset; pin reset keeps the run bit, so a set bit releases it with the pin
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "port_cfg.svh"
module debug_trace_monitor_port #(
	parameter logic [31:0] IO8_BASE = 32'hFFFF_8000,
	parameter logic [31:0] IO8_LIMIT = 32'hFFFF_83FF,
	parameter logic [31:0] EXT_BASE = 32'h0040_0000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic soft_standby,
	input wire logic branch_valid,
	input wire logic [31:0] branch_addr,
	output logic mem_req,
	output logic mem_write,
	output logic [1:0] mem_size,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic mem_err,
	input wire logic [31:0] mem_rdata,
	input wire logic port_reset_n,
	input wire logic mode_select,
	input wire logic link_clock_i,
	output logic link_clock_o,
	output logic link_clock_oe,
	input wire logic frame_sync_n_i,
	output logic frame_sync_n_o,
	output logic frame_sync_n_oe,
	input wire logic [3:0] link_nibble_i,
	output logic [3:0] link_nibble_o,
	output logic link_nibble_oe
);
	logic [7:0] pins_sync;
	logic [2:0] ctrl_reg;
	logic mode_reg;
	logic ph_reg;
	logic pend_reg;
	logic wait_reg;
	logic [31:0] pend_addr_reg;
	logic [31:0] cur_addr_reg;
	logic [1:0] cur_code_reg;
	logic [2:0] nib_idx_reg;
	logic [3:0] tr_nib_reg;
	logic tr_sync_reg;
	logic [31:0] cmp_reg;
	port_pkg::trace_state_type tr_state;
	port_pkg::mon_state_type mon_state;
	logic lclk_prev_reg;
	logic [3:0] mcmd_reg;
	logic [2:0] midx_reg;
	logic [3:0] stat_reg;
	logic [31:0] rdata_reg;
	logic bus_fault;
	logic [3:0] age_reg;

	bit_sync #(.WIDTH(8), .RESET_VALUE(8'h00)) u_pin_sync (
		.clk(pclk),
		.rst_n(presetn),
		.async_in({port_reset_n, mode_select, link_clock_i, frame_sync_n_i,
			link_nibble_i}),
		.sync_out(pins_sync)
	);

	wire pin_rst_n = pins_sync[7];
	wire pin_mode = pins_sync[6];
	wire pin_lclk = pins_sync[5];
	wire pin_fsync_n = pins_sync[4];
	wire [3:0] pin_nib = pins_sync[3:0];

	wire stop = ctrl_reg[`CTRL_STOP_BIT];
	wire port_rst = !pin_rst_n || !ctrl_reg[`CTRL_RUN_BIT] || stop;
	wire trace_on = !port_rst && !mode_reg;
	wire mon_on = !port_rst && mode_reg;
	wire tick = trace_on && !soft_standby && ph_reg;

	// Register bus: one wait state, writes land on the completing edge
	wire apb_access = psel && penable;
	wire apb_first = apb_access && !pready;
	wire apb_commit = apb_access && pready;
	wire sel_ctrl = (paddr == `CTRL_OFF);
	wire sel_stat = (paddr == `STAT_OFF);
	wire sel_cmp = (paddr == `CMP_OFF);
	wire mapped = sel_ctrl || sel_stat || sel_cmp;
	wire [31:0] stat_word = {24'h00_0000, mon_state, tr_state, soft_standby,
		!port_rst, mode_reg};
	wire [31:0] read_mux = sel_ctrl ? {29'h0000_0000, ctrl_reg} :
		sel_stat ? stat_word : sel_cmp ? cmp_reg : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			ctrl_reg <= `CTRL_RESET;
		end else begin
			pready <= apb_first;
			pslverr <= apb_first && !mapped;
			if (apb_first && !pwrite) begin
				prdata <= read_mux;
			end
			if (apb_commit && pwrite && sel_ctrl) begin
				ctrl_reg <= pwdata[2:0];
			end
		end
	end

	// Mode is only taken while the port is held in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= 1'b0;
		end else if (port_rst) begin
			mode_reg <= pin_mode;
		end
	end

	// Branch trace: size choice and nibble selection
	wire m4 = pend_addr_reg[31:4] == cmp_reg[31:4];
	wire m8 = pend_addr_reg[31:8] == cmp_reg[31:8];
	wire m16 = pend_addr_reg[31:16] == cmp_reg[31:16];
	wire [1:0] size_code = m4 ? 2'h0 : m8 ? 2'h1 : m16 ? 2'h2 : 2'h3;
	wire [2:0] last_idx = 3'((4'h1 << cur_code_reg) - 4'h1);
	wire start = tick && pend_reg && wait_reg;
	wire in_addr = tr_state == port_pkg::TR_ADDR;
	wire last_out = tick && in_addr && (nib_idx_reg == last_idx);
	wire [2:0] idx_inc = nib_idx_reg + 3'h1;
	wire [3:0] next_nib = cur_addr_reg[{idx_inc, 2'b00} +: 4];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_reg <= 1'b0;
			pend_reg <= 1'b0;
			wait_reg <= 1'b0;
			pend_addr_reg <= 32'h0000_0000;
		end else if (!trace_on) begin
			ph_reg <= 1'b0;
			pend_reg <= 1'b0;
			wait_reg <= 1'b0;
		end else begin
			if (!soft_standby) begin
				ph_reg <= !ph_reg;
			end
			if (branch_valid) begin
				pend_reg <= 1'b1;
				wait_reg <= 1'b0;
				pend_addr_reg <= branch_addr;
			end else if (tick && pend_reg) begin
				// Second falling link edge after the branch starts the header
				wait_reg <= 1'b1;
				pend_reg <= !wait_reg;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tr_state <= port_pkg::TR_IDLE;
			tr_nib_reg <= `IDLE_NIB;
			tr_sync_reg <= 1'b1;
			cur_addr_reg <= 32'h0000_0000;
			cur_code_reg <= 2'h0;
			nib_idx_reg <= 3'h0;
			cmp_reg <= `CMP_RESET;
		end else if (!trace_on) begin
			tr_state <= port_pkg::TR_IDLE;
			tr_nib_reg <= `IDLE_NIB;
			tr_sync_reg <= 1'b1;
			nib_idx_reg <= 3'h0;
			cmp_reg <= `CMP_RESET;
		end else if (start) begin
			// Restart abandons any address still going out
			tr_state <= port_pkg::TR_HEADER;
			cur_addr_reg <= pend_addr_reg;
			cur_code_reg <= size_code;
			tr_nib_reg <= {`HEADER_TAG, size_code};
			tr_sync_reg <= 1'b1;
		end else if (tick && tr_state == port_pkg::TR_HEADER) begin
			tr_state <= port_pkg::TR_ADDR;
			nib_idx_reg <= 3'h0;
			tr_nib_reg <= cur_addr_reg[3:0];
			tr_sync_reg <= 1'b0;
		end else if (last_out) begin
			tr_state <= port_pkg::TR_IDLE;
			tr_nib_reg <= `IDLE_NIB;
			tr_sync_reg <= 1'b1;
			cmp_reg <= cur_addr_reg;
		end else if (tick && in_addr) begin
			nib_idx_reg <= idx_inc;
			tr_nib_reg <= next_nib;
		end
	end

	// RAM monitor: link clock edges found by sampling the synchronised pin
	wire lrise = pin_lclk && !lclk_prev_reg;
	wire fs = !pin_fsync_n;
	wire take = lrise && fs;
	wire is_read = mcmd_reg == `CMD_READ;
	wire is_write = mcmd_reg == `CMD_WRITE;
	wire bad_cmd = !(is_read || is_write) || (mem_size == `SIZE_BAD);
	wire [2:0] data_last = 3'((4'h2 << mem_size) - 4'h1);
	wire [3:0] rd_nib = rdata_reg[{midx_reg, 2'b00} +: 4];
	wire mon_drive = (mon_state == port_pkg::MON_ACCESS) ||
		(mon_state == port_pkg::MON_STATUS) || (mon_state == port_pkg::MON_READ);
	wire [3:0] mon_nib = (mon_state == port_pkg::MON_READ) ? rd_nib :
		soft_standby ? `NOT_READY : stat_reg;

	access_check #(
		.IO8_BASE(IO8_BASE),
		.IO8_LIMIT(IO8_LIMIT),
		.EXT_BASE(EXT_BASE)
	) u_access_check (
		.addr(mem_addr),
		.size(mem_size),
		.single_chip(ctrl_reg[`CTRL_SINGLE_BIT]),
		.fault(bus_fault)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lclk_prev_reg <= 1'b0;
		end else begin
			lclk_prev_reg <= pin_lclk;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mon_state <= port_pkg::MON_CMD;
			mcmd_reg <= 4'h0;
			midx_reg <= 3'h0;
			stat_reg <= `NOT_READY;
			rdata_reg <= 32'h0000_0000;
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			mem_size <= `SIZE_BYTE;
			mem_addr <= 32'h0000_0000;
			mem_wdata <= 32'h0000_0000;
		end else if (!mon_on) begin
			mon_state <= port_pkg::MON_CMD;
			midx_reg <= 3'h0;
			stat_reg <= `NOT_READY;
			mem_req <= 1'b0;
		end else begin
			case (mon_state)
			port_pkg::MON_CMD: begin
				stat_reg <= `NOT_READY;
				if (take) begin
					mcmd_reg <= pin_nib;
					mon_state <= port_pkg::MON_SIZE;
				end
			end
			port_pkg::MON_SIZE: begin
				if (take) begin
					mem_size <= pin_nib[1:0];
					midx_reg <= 3'h0;
					mon_state <= port_pkg::MON_ADDR;
				end
			end
			port_pkg::MON_ADDR: begin
				if (take) begin
					mem_addr[{midx_reg, 2'b00} +: 4] <= pin_nib;
					midx_reg <= midx_reg + 3'h1;
					if (midx_reg == `ADDR_LAST) begin
						mon_state <= is_write ? port_pkg::MON_DATA :
							port_pkg::MON_ACCESS;
					end
				end
			end
			port_pkg::MON_DATA: begin
				if (take) begin
					mem_wdata[{midx_reg, 2'b00} +: 4] <= pin_nib;
					midx_reg <= midx_reg + 3'h1;
					if (midx_reg == data_last) begin
						midx_reg <= 3'h0;
						mon_state <= port_pkg::MON_ACCESS;
					end
				end
			end
			port_pkg::MON_ACCESS: begin
				if (mem_req) begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						rdata_reg <= mem_rdata;
						stat_reg <= mem_err ? `BUS_ERR : `READY;
						mon_state <= port_pkg::MON_STATUS;
					end
				end else if (!soft_standby) begin
					if (bad_cmd) begin
						stat_reg <= `CMD_ERR;
						mon_state <= port_pkg::MON_STATUS;
					end else if (bus_fault) begin
						stat_reg <= `BUS_ERR;
						mon_state <= port_pkg::MON_STATUS;
					end else begin
						mem_req <= 1'b1;
						mem_write <= is_write;
					end
				end
			end
			port_pkg::MON_STATUS: begin
				if (lrise && !fs) begin
					midx_reg <= 3'h0;
					mon_state <= (is_read && stat_reg == `READY) ?
						port_pkg::MON_READ : port_pkg::MON_CMD;
				end
			end
			port_pkg::MON_READ: begin
				if (lrise) begin
					midx_reg <= midx_reg + 3'h1;
					if (midx_reg == data_last) begin
						mon_state <= port_pkg::MON_CMD;
					end
				end
			end
			default: begin
				mon_state <= port_pkg::MON_CMD;
			end
			endcase
		end
	end

	// Pins: floated on stop, high or input in reset, else by mode
	wire pins_drive = !stop && (port_rst ? !pin_mode : !mode_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_clock_o <= 1'b1;
			link_clock_oe <= 1'b0;
			frame_sync_n_o <= 1'b1;
			frame_sync_n_oe <= 1'b0;
			link_nibble_o <= `PIN_HIGH_NIB;
			link_nibble_oe <= 1'b0;
		end else begin
			link_clock_o <= port_rst || ph_reg;
			link_clock_oe <= pins_drive;
			frame_sync_n_o <= port_rst || tr_sync_reg;
			frame_sync_n_oe <= pins_drive;
			link_nibble_o <= port_rst ? `PIN_HIGH_NIB :
				mode_reg ? mon_nib : tr_nib_reg;
			link_nibble_oe <= pins_drive || (mon_on && mon_drive && !stop);
		end
	end

	// Cycles since the last branch, read only by the header timing check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age_reg <= 4'h0;
		end else if (branch_valid) begin
			age_reg <= 4'h1;
		end else if (age_reg != 4'hF) begin
			age_reg <= age_reg + 4'h1;
		end
	end

	AST_HALF_CLOCK: assert property (@(posedge pclk) disable iff (!presetn)
		(trace_on && !soft_standby) |=> (ph_reg != $past(ph_reg)))
		else $error("trace link clock did not toggle");
	AST_IDLE_PATTERN: assert property (@(posedge pclk) disable iff (!presetn)
		(tr_state == port_pkg::TR_IDLE) |-> (tr_nib_reg == `IDLE_NIB && tr_sync_reg))
		else $error("idle trace nibble wrong");
	AST_HEADER_CODE: assert property (@(posedge pclk) disable iff (!presetn)
		start |=> (tr_nib_reg == {`HEADER_TAG, $past(size_code)}) && tr_sync_reg)
		else $error("trace header code wrong");
	AST_SYNC_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		(tr_state == port_pkg::TR_HEADER && tick && !start) |=>
		(!tr_sync_reg && tr_nib_reg == cur_addr_reg[3:0]))
		else $error("first address nibble wrong");
	AST_CMP_ONLY_DONE: assert property (@(posedge pclk) disable iff (!presetn)
		(cmp_reg != $past(cmp_reg)) |-> ($past(last_out) || $past(!trace_on)))
		else $error("compared address changed without completion");
	AST_HEADER_DELAY: assert property (@(posedge pclk)
		disable iff (!presetn || !trace_on || soft_standby)
		start |-> (age_reg >= `HDR_DELAY_MIN && age_reg <= `HDR_DELAY_MAX))
		else $error("header delay out of range");
	AST_STANDBY_NOT_READY: assert property (@(posedge pclk)
		disable iff (!presetn)
		(mon_on && soft_standby && mon_state == port_pkg::MON_ACCESS && !mem_req)
		|=> !mem_req ##1 (link_nibble_o == `NOT_READY || !mon_on))
		else $error("monitor progressed in standby");
	AST_CMD_ERROR: assert property (@(posedge pclk) disable iff (!presetn)
		(mon_on && mon_state == port_pkg::MON_ACCESS && !mem_req && bad_cmd &&
		!soft_standby) |=> (stat_reg == `CMD_ERR && !mem_req))
		else $error("undefined command not flagged");
	AST_RESET_PINS: assert property (@(posedge pclk) disable iff (!presetn)
		(port_rst && !stop && !pin_mode) |=> (link_clock_oe && link_clock_o &&
		frame_sync_n_oe && frame_sync_n_o && link_nibble_o == `PIN_HIGH_NIB))
		else $error("reset pin levels wrong");
	AST_STOP_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
		stop |=> !(link_clock_oe || frame_sync_n_oe || link_nibble_oe))
		else $error("pins driven in module stop");
endmodule

// ===== dv/debug_tool_model.sv
// Debug probe model for the monitor side of the nibble link
`timescale 1ns/1ps
module debug_tool_model (
	input wire logic active,
	input wire logic clk_o,
	input wire logic clk_oe,
	input wire logic sync_o,
	input wire logic sync_oe,
	input wire logic [3:0] nib_o,
	input wire logic nib_oe,
	output logic link_clock,
	output logic frame_sync_n,
	output logic [3:0] link_nibble
);
	logic ck = 1'b0;
	logic sy = 1'b1;
	logic drv = 1'b0;
	logic [3:0] dv = 4'h0;
	// Released lines show a flipped value so nothing matches by luck
	assign link_clock = clk_oe ? clk_o : (active ? ck : ~clk_o);
	assign frame_sync_n = sync_oe ? sync_o : (active ? sy : ~sync_o);
	assign link_nibble = nib_oe ? nib_o : (drv ? dv : ~dv);
	// Clock stands low between frames
	task tick(output logic [3:0] s);
		#40 ck = 1'b1;
		s = link_nibble;
		#40 ck = 1'b0;
	endtask
	task clocks(input int n);
		logic [3:0] s;
		#1;
		repeat (n) tick(s);
	endtask
	task frame(input logic [3:0] c, input logic [3:0] z,
		input logic [31:0] a, input logic [31:0] d, input int nd,
		output logic [3:0] st, output logic [31:0] rd);
		logic [3:0] s;
		#1 sy = 1'b0;
		drv = 1'b1;
		dv = c;
		tick(s);
		dv = z;
		tick(s);
		for (int i = 0; i < 8; i++) begin
			dv = a[4*i+:4];
			tick(s);
		end
		for (int i = 0; i < nd && c == 4'h2; i++) begin
			dv = d[4*i+:4];
			tick(s);
		end
		drv = 1'b0;
		st = 4'h0;
		for (int i = 0; i < 100 && st === 4'h0; i++) tick(st);
		#40 ck = 1'b1;
		sy = 1'b1;
		#40 ck = 1'b0;
		rd = 32'h0;
		for (int i = 0; i < nd && c == 4'h1 && st == 4'h1; i++) begin
			tick(s);
			rd[4*i+:4] = s;
		end
	endtask
endmodule

// ===== dv/test_debug_trace_monitor_port.sv
// Self-checking bench for the debug trace and monitor port
`timescale 1ns/1ps
module test_debug_trace_monitor_port;
	localparam logic [31:0] IO8 = 32'hFFFF_8000;
	localparam logic [31:0] EXT = 32'h0040_0000;
	// cmd, size, nibbles, status, flags (bit0 access, bit1 error), addr
	localparam logic [63:0] MT [11] = '{
		64'h2281_1000_0000_0100, 64'h1281_1000_0000_0200,
		64'h2021_1000_0000_0103, 64'h2141_1000_0000_0102,
		64'h1105_0000_0000_0101, 64'h1205_0000_0000_0102,
		64'h1205_0000_FFFF_8000, 64'h1285_3000_0000_0204,
		64'h7203_0000_0000_0300, 64'h1205_0000_0040_0000,
		64'h1303_0000_0000_0100};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, soft_standby = 1'b0, branch_valid = 1'b0;
	logic mem_ack = 1'b0, mem_err = 1'b0, port_reset_n = 1'b0;
	logic mode_select = 1'b0, active = 1'b0, lck = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, branch_addr = 32'h0, mem_rdata = 32'h0;
	logic [31:0] prdata, mem_addr, mem_wdata, last_rd, cmp = 32'h0;
	logic [31:0] seed = 32'hF68A;
	logic pready, pslverr, mem_req, mem_write, link_clock_i, link_clock_o;
	logic link_clock_oe, frame_sync_n_i, frame_sync_n_o, frame_sync_n_oe;
	logic link_nibble_oe;
	logic [1:0] mem_size;
	logic [3:0] link_nibble_i, link_nibble_o;
	logic [4:0] tq [$];
	logic [67:0] mq [$];
	logic [67:0] me;
	logic [31:0] mk;
	int bad_count = 0, checks = 0, skip = 0, cyc = 0;
	bit tr_on = 1'b0;
	wire logic hdr = frame_sync_n_o && link_nibble_o[3:2] == 2'h2;

	debug_trace_monitor_port #(.IO8_BASE(IO8), .EXT_BASE(EXT))
		i_debug_trace_monitor_port (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .soft_standby,
		.branch_valid, .branch_addr, .mem_req, .mem_write, .mem_size,
		.mem_addr, .mem_wdata, .mem_ack, .mem_err, .mem_rdata, .port_reset_n,
		.mode_select, .link_clock_i, .link_clock_o, .link_clock_oe,
		.frame_sync_n_i, .frame_sync_n_o, .frame_sync_n_oe, .link_nibble_i,
		.link_nibble_o, .link_nibble_oe);
	debug_tool_model i_debug_tool_model (.active, .clk_o(link_clock_o),
		.clk_oe(link_clock_oe), .sync_o(frame_sync_n_o),
		.sync_oe(frame_sync_n_oe), .nib_o(link_nibble_o),
		.nib_oe(link_nibble_oe), .link_clock(link_clock_i),
		.frame_sync_n(frame_sync_n_i), .link_nibble(link_nibble_i));

	initial forever #4 pclk = ~pclk;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input string n, input logic [63:0] s, input logic [63:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task done(input string n);
		$display("test %s done", n);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] ed, input logic ee);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!w && !ee) chk("prdata", prdata, ed);
		chk("pslverr", pslverr, ee);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pulse(input logic [31:0] a);
		@(posedge pclk);
		branch_valid <= 1'b1;
		branch_addr <= a;
		@(posedge pclk);
		branch_valid <= 1'b0;
		branch_addr <= xs();
	endtask
	task branch(input logic [31:0] a);
		logic [1:0] z;
		z = a[31:4] == cmp[31:4] ? 2'h0 : a[31:8] == cmp[31:8] ? 2'h1 :
			a[31:16] == cmp[31:16] ? 2'h2 : 2'h3;
		tq.push_back({3'h6, z});
		for (int i = 0; i < (1 << z); i++) tq.push_back({1'b0, a[4*i+:4]});
		cmp = a;
		pulse(a);
		repeat (40) @(posedge pclk);
	endtask

	// Trace watcher: one sample per rising link clock
	always @(posedge pclk) begin
		lck <= link_clock_o;
		if (tr_on && link_clock_o && !lck && (skip == 0 || (skip == 2 && hdr))) begin
			if (frame_sync_n_o && !hdr)
				chk("idle", {frame_sync_n_o, link_nibble_o}, 5'h13);
			else begin
				skip = 0;
				chk("trace", {frame_sync_n_o, link_nibble_o}, tq.size() ? tq.pop_front() : 'x);
			end
		end
	end
	// Memory side: any unexpected request meets an unknown note
	initial forever begin
		@(posedge pclk);
		if (mem_req === 1'b1) begin
			me = mq.size() ? mq.pop_front() : 'x;
			chk("mem_req", {mem_write, mem_size, mem_addr}, me[66:32]);
			// Only the bytes of the requested size carry new data
			mk = ~(32'hFFFF_FFFF << (8 << me[65:64]));
			if (me[66]) chk("wdata", mem_wdata & mk, me[31:0] & mk);
			repeat (xs() % 3) @(posedge pclk);
			last_rd = xs();
			mem_ack <= 1'b1;
			mem_err <= me[67];
			mem_rdata <= last_rd;
			@(posedge pclk);
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
		end
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			end_sim();
		end
	end

	initial begin
		logic [63:0] t;
		logic [31:0] d, rd;
		logic [3:0] st;
		logic [4:0] v;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("rst_pins", {link_clock_oe, frame_sync_n_oe, link_nibble_oe, link_clock_o, frame_sync_n_o, link_nibble_o}, 9'h1FF);
		apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
		port_reset_n <= 1'b1;
		apb(1'b1, 12'h000, 32'h1, 32'h0, 1'b0);
		apb(1'b0, 12'h000, 32'h0, 32'h1, 1'b0);
		repeat (8) @(posedge pclk);
		tr_on = 1'b1;
		branch(32'h5);
		for (int k = 0; k < 4; k++) branch(cmp ^ (32'h9 << (4 * ((1 << k) - 1))));
		repeat (3) branch(xs());
		done("trace");
		skip = 1;
		pulse(cmp ^ 32'h8000_0000);
		repeat (10) @(posedge pclk);
		tq.delete();
		skip = 2;
		branch(cmp ^ 32'h6);
		done("abort");
		soft_standby <= 1'b1;
		repeat (3) @(posedge pclk);
		v = {link_clock_o, link_nibble_o};
		repeat (8) @(posedge pclk);
		chk("standby", {link_clock_o, link_nibble_o}, v);
		soft_standby <= 1'b0;
		branch(xs());
		done("standby");
		chk("tq_left", tq.size(), 0);
		apb(1'b0, 12'h008, 32'h0, cmp, 1'b0);
		tr_on = 1'b0;
		apb(1'b1, 12'h000, 32'h3, 32'h0, 1'b0);
		repeat (4) @(posedge pclk);
		chk("stop_oe", {link_clock_oe, frame_sync_n_oe, link_nibble_oe}, 3'h0);
		apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b0);
		apb(1'b1, 12'h000, 32'h0, 32'h0, 1'b0);
		port_reset_n <= 1'b0;
		@(posedge pclk);
		mode_select <= 1'b1;
		active = 1'b1;
		i_debug_tool_model.clocks(3);
		@(posedge pclk);
		port_reset_n <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b1, 12'h000, 32'h1, 32'h0, 1'b0);
		chk("mon_oe", {link_clock_oe, frame_sync_n_oe, link_nibble_oe}, 3'h0);
		for (int i = 0; i < 11; i++) begin
			t = MT[i];
			d = xs();
			// Case 9 onwards runs in single-chip mode for the external fault
			if (i == 9) apb(1'b1, 12'h000, 32'h5, 32'h0, 1'b0);
			if (t[44]) mq.push_back({t[45], t[63:60] == 4'h2, t[57:56], t[31:0], d});
			i_debug_tool_model.frame(t[63:60], t[59:56], t[31:0], d, t[55:52], st, rd);
			chk("status", st, t[51:48]);
			if (t[63:60] == 4'h1 && t[51:48] == 4'h1) chk("rdata", rd, last_rd);
			done("monitor");
		end
		// Standby holds the access back; status must stay not ready
		@(posedge pclk);
		soft_standby <= 1'b1;
		fork
			begin
				repeat (250) @(posedge pclk);
				chk("mon_standby", {mem_req, link_nibble_o}, 5'h00);
				soft_standby <= 1'b0;
			end
		join_none
		mq.push_back({4'h2, 32'h0000_0300, d});
		i_debug_tool_model.frame(4'h1, 4'h2, 32'h0000_0300, d, 8, st, rd);
		chk("sby_status", st, 4'h1);
		chk("sby_rdata", rd, last_rd);
		chk("mq_left", mq.size(), 0);
		done("mon_standby");
		end_sim();
	end
endmodule
